// ---- core/tmw_pkg.sv ----
// Package of register map, field layout and mode codes for the 8-bit timer
package tmw_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CONTROL = 8'hb0;
	localparam logic [7:0] OFF_COUNT = 8'hb2;
	localparam logic [7:0] OFF_COMPARE = 8'hb3;
	localparam logic [7:0] OFF_MASK = 8'h70;
	localparam logic [7:0] OFF_FLAGS = 8'h37;

	// ==========================================================
	// Control register fields
	localparam int BIT_FORCE = 7;
	localparam int BIT_WAVE0 = 6;
	localparam int BIT_COM1 = 5;
	localparam int BIT_COM0 = 4;
	localparam int BIT_WAVE1 = 3;
	localparam int BIT_TICK_HI = 2;

	// Mask and flag fields
	localparam int BIT_CMP = 1;
	localparam int BIT_OVF = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;

	// ==========================================================
	// Counter limits and prescaler width
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam int PRE_WIDTH = 10;

	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'b00,
		WAVE_PHASE = 2'b01,
		WAVE_CLEAR = 2'b10,
		WAVE_FAST = 2'b11
	} tmw_wave_t;

	typedef enum logic [1:0] {
		COM_OFF = 2'b00,
		COM_TOGGLE = 2'b01,
		COM_CLEAR = 2'b10,
		COM_SET = 2'b11
	} tmw_com_t;

endpackage

// ---- core/tmw_prescaler.sv ----
// Prescaler that makes the selected timer tick from the source clock
`timescale 1ns/10ps
module tmw_prescaler
#(
	parameter int WIDTH = tmw_pkg::PRE_WIDTH
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Tick selection and output
	tmw_tick_if.source tk
);

	// ==========================================================
	// Free-running divider
	logic [WIDTH-1:0] div;
	logic [WIDTH-1:0] next_div;
	logic [WIDTH-1:0] allOnes;

	assign next_div = div + {{(WIDTH-1){1'b0}}, 1'b1};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			div <= '0;
		else
			div <= next_div;
	end

	// A tap fires when the low bits of the divider are all ones
	assign allOnes = div;

	// Stop, /1, /8, /32, /64, /128, /256, /1024
	always_comb
	begin
		case (tk.tickSel) // [R12]
			3'd0: tk.tick = 1'b0;
			3'd1: tk.tick = 1'b1;
			3'd2: tk.tick = &allOnes[2:0];
			3'd3: tk.tick = &allOnes[4:0];
			3'd4: tk.tick = &allOnes[5:0];
			3'd5: tk.tick = &allOnes[6:0];
			3'd6: tk.tick = &allOnes[7:0];
			default: tk.tick = &allOnes[9:0];
		endcase
	end

endmodule

// ---- core/tmw_tick_if.sv ----
// Interface carrying the tick from the prescaler to the counter core
`timescale 1ns/10ps
interface tmw_tick_if;
	logic [2:0] tickSel;
	logic tick;
	modport source (input tickSel, output tick);
	modport sink (output tickSel, input tick);
endinterface

// ---- core/tmw_timer.sv ----
// Top of the 8-bit timer with one compare channel and waveform output
//
// Contract
// [R01] Force strobe acts only in normal and clear-on-match modes.
// [R02] Software keeps force strobe zero when writing control in PWM modes.
// [R03] Force strobe makes an immediate compare action per current output mode.
// [R04] Forced compare sets no flag and does not clear the counter.
// [R05] Force strobe bit always reads zero.
// [R06] Mode field: 0 normal, 1 phase PWM, 2 clear-on-match, 3 fast PWM.
// [R07] Nonzero output mode overrides port; driver enabled by direction bit.
// [R08] Non-PWM codes: off, toggle, clear, set on match.
// [R09] Fast PWM: 10 clear on match set at bottom, 11 inverse.
// [R10] Phase PWM: 10 clear up-match set down-match, 11 inverse.
// [R11] In PWM, compare equal to top with upper bit acts at top.
// [R12] Tick select: stop, /1, /8, /32, /64, /128, /256, /1024.
// [R13] Counter register gives direct read and write of the count.
// [R14] A counter write blocks compare match on the next tick.
// [R15] Software avoids changing the counter while it runs.
// [R16] Compare value checked against counter every tick.
// [R17] Compare request when enable, global enable and flag all set.
// [R18] Overflow request when enable, global enable and flag all set.
// [R19] Compare flag set on match, cleared by vector or writing one.
// [R20] Phase PWM overflow flag set at bottom; cleared by vector or one.
// [R21] Counter wraps at top, or counts up and down in phase PWM.
// [R22] Compare value buffered and loaded at top or bottom in PWM.
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module tmw_timer
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Interrupt system
	input wire logic globalIrqEnable,
	input wire logic compareVectorAck,
	input wire logic overflowVectorAck,
	output logic compareIrqReq,
	output logic overflowIrqReq,
	// Pin
	input wire logic pinDirection,
	input wire logic portData,
	output logic compareOutPin,
	output logic compareOutPinOe_n
);

	// ==========================================================
	// Registers
	logic [7:0] timerControl;
	logic [7:0] countValue;
	logic [7:0] compareBuffer;
	logic [7:0] compareValueA;
	logic [1:0] interruptMask;
	logic compareFlag;
	logic overflowFlag;
	logic countDown;
	logic blockMatch;
	logic waveOut;
	logic [7:0] next_count;
	logic next_countDown;
	logic next_wave;

	// ==========================================================
	// Address decode
	wire wrControl = regWrite && regAddr == tmw_pkg::OFF_CONTROL;
	wire wrCount = regWrite && regAddr == tmw_pkg::OFF_COUNT;
	wire wrCompare = regWrite && regAddr == tmw_pkg::OFF_COMPARE;
	wire wrMask = regWrite && regAddr == tmw_pkg::OFF_MASK;
	wire wrFlags = regWrite && regAddr == tmw_pkg::OFF_FLAGS;

	// ==========================================================
	// Field decode
	wire [1:0] waveModeSel = {timerControl[tmw_pkg::BIT_WAVE1],
		timerControl[tmw_pkg::BIT_WAVE0]}; // [R06]
	wire [1:0] compareOutMode = timerControl[tmw_pkg::BIT_COM1:
		tmw_pkg::BIT_COM0];
	wire [2:0] tickSourceSel = timerControl[tmw_pkg::BIT_TICK_HI:0];
	wire isPhase = waveModeSel == tmw_pkg::WAVE_PHASE;
	wire isFast = waveModeSel == tmw_pkg::WAVE_FAST;
	wire isClear = waveModeSel == tmw_pkg::WAVE_CLEAR;
	wire isPwm = isPhase || isFast;
	wire [7:0] topValue = isClear ? compareValueA : tmw_pkg::CNT_MAX; // [R06]

	// ==========================================================
	// Prescaler
	tmw_tick_if tk();
	assign tk.tickSel = tickSourceSel;

	tmw_prescaler u_pre
	(
		.clk(clk),
		.arst_n(arst_n),
		.tk(tk)
	);

	wire tick = tk.tick;

	// ==========================================================
	// Counter sequence and events
	wire atTop = countValue == topValue;
	wire atBottom = countValue == tmw_pkg::CNT_BOTTOM;
	wire rawMatch = countValue == compareValueA; // [R16]
	wire match = tick && rawMatch && !blockMatch; // [R14]
	// PWM with compare at top: action moves to top instead of the match
	wire topSpecial = isPwm && compareValueA == tmw_pkg::CNT_MAX &&
		compareOutMode[1]; // [R11]
	wire overflowEvent = tick && (isPhase ? (atBottom && countDown) :
		countValue == tmw_pkg::CNT_MAX); // [R20]
	wire bottomEvent = tick && (isPhase ? atBottom : atTop);
	// Force strobe only in the non-PWM modes
	wire forceEvent = wrControl && regWrData[tmw_pkg::BIT_FORCE] &&
		!(regWrData[tmw_pkg::BIT_WAVE0]); // [R01]
	wire loadCompare = isFast ? bottomEvent : (tick && atTop); // [R22]
	// The strobe acts on the output mode written beside it in the same write
	wire [1:0] forceMode = regWrData[tmw_pkg::BIT_COM1:tmw_pkg::BIT_COM0];

	always_comb
	begin
		next_count = countValue;
		next_countDown = countDown;
		if (tick)
		begin
			if (isPhase)
			begin
				if (!countDown && countValue == tmw_pkg::CNT_MAX)
				begin
					next_countDown = 1'b1;
					next_count = countValue - 8'h01;
				end
				else if (countDown && atBottom)
				begin
					next_countDown = 1'b0;
					next_count = countValue + 8'h01;
				end
				else if (countDown)
					next_count = countValue - 8'h01;
				else
					next_count = countValue + 8'h01; // [R21]
			end
			else
			begin
				next_countDown = 1'b0;
				next_count = atTop ? tmw_pkg::CNT_BOTTOM :
					countValue + 8'h01; // [R21]
			end
		end
	end

	// ==========================================================
	// Waveform generator
	always_comb
	begin
		next_wave = waveOut;
		if (forceEvent) // [R03]
		begin
			case (forceMode) // [R08]
				tmw_pkg::COM_TOGGLE: next_wave = !waveOut;
				tmw_pkg::COM_CLEAR: next_wave = 1'b0;
				tmw_pkg::COM_SET: next_wave = 1'b1;
				default: next_wave = waveOut;
			endcase
		end
		else if (!isPwm)
		begin
			if (match)
			begin
				case (compareOutMode) // [R08]
					tmw_pkg::COM_TOGGLE: next_wave = !waveOut;
					tmw_pkg::COM_CLEAR: next_wave = 1'b0;
					tmw_pkg::COM_SET: next_wave = 1'b1;
					default: next_wave = waveOut;
				endcase
			end
		end
		else if (compareOutMode[1])
		begin
			if (topSpecial && tick && countValue == tmw_pkg::CNT_MAX)
				next_wave = !compareOutMode[0]; // [R11]
			else if (isFast && bottomEvent)
				next_wave = !compareOutMode[0]; // [R09]
			else if (isFast && match && !topSpecial)
				next_wave = compareOutMode[0]; // [R09]
			else if (isPhase && match && !topSpecial)
				next_wave = compareOutMode[0] ^ countDown; // [R10]
		end
	end

	// ==========================================================
	// Register updates
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timerControl <= tmw_pkg::RST_CONTROL;
			countValue <= tmw_pkg::RST_COUNT;
			countDown <= 1'b0;
			blockMatch <= 1'b0;
			waveOut <= 1'b0;
		end
		else
		begin
			// Strobe bit is never stored
			if (wrControl)
				timerControl <= {1'b0, regWrData[6:0]}; // [R05]
			countValue <= wrCount ? regWrData : next_count; // [R13]
			countDown <= next_countDown;
			// Block holds until the next tick has gone past
			if (wrCount)
				blockMatch <= 1'b1; // [R14]
			else if (tick)
				blockMatch <= 1'b0;
			waveOut <= next_wave;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			compareBuffer <= tmw_pkg::RST_COMPARE;
			compareValueA <= tmw_pkg::RST_COMPARE;
			interruptMask <= tmw_pkg::RST_MASK[1:0];
		end
		else
		begin
			if (wrCompare)
				compareBuffer <= regWrData;
			if (wrCompare && !isPwm)
				compareValueA <= regWrData;
			else if (isPwm && loadCompare)
				compareValueA <= compareBuffer; // [R22]
			if (wrMask)
				interruptMask <= regWrData[1:0];
		end
	end

	// Set wins over clear; force never sets the flag
	wire clrCmp = compareVectorAck ||
		(wrFlags && regWrData[tmw_pkg::BIT_CMP]);
	wire clrOvf = overflowVectorAck ||
		(wrFlags && regWrData[tmw_pkg::BIT_OVF]);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			compareFlag <= 1'b0;
			overflowFlag <= 1'b0;
		end
		else
		begin
			compareFlag <= match || (compareFlag && !clrCmp); // [R19] [R04]
			overflowFlag <= overflowEvent || (overflowFlag && !clrOvf); // [R20]
		end
	end

	// ==========================================================
	// Read back
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			regRdData <= 8'h00;
		else if (!regRead)
			regRdData <= 8'h00;
		else
		begin
			case (regAddr)
				tmw_pkg::OFF_CONTROL: regRdData <= timerControl; // [R05]
				tmw_pkg::OFF_COUNT: regRdData <= countValue;
				tmw_pkg::OFF_COMPARE: regRdData <= isPwm ? compareBuffer :
					compareValueA;
				tmw_pkg::OFF_MASK: regRdData <= {6'h00, interruptMask};
				tmw_pkg::OFF_FLAGS: regRdData <= {6'h00, compareFlag,
					overflowFlag};
				default: regRdData <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Outputs
	assign compareIrqReq = globalIrqEnable &&
		interruptMask[tmw_pkg::BIT_CMP] && compareFlag; // [R17]
	assign overflowIrqReq = globalIrqEnable &&
		interruptMask[tmw_pkg::BIT_OVF] && overflowFlag; // [R18]
	// Any nonzero output mode takes the pin from the port
	assign compareOutPin = (compareOutMode != tmw_pkg::COM_OFF) ? waveOut :
		portData; // [R07]
	assign compareOutPinOe_n = !pinDirection; // [R07]

endmodule

// ---- dv/tmw_timer_chk.sv ----
// Checker of register port, pin and request behaviour of the timer
`timescale 1ns/10ps
module tmw_timer_chk
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Requests and pin
	input wire logic globalIrqEnable,
	input wire logic compareIrqReq,
	input wire logic overflowIrqReq,
	input wire logic pinDirection,
	input wire logic portData,
	input wire logic compareOutPin,
	input wire logic compareOutPinOe_n
);
	// ==========================================================
	// Shadow of the output mode field, seen through control writes
	logic [1:0] outMode;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			outMode <= 2'b00;
		else if (regWrite && regAddr == tmw_pkg::OFF_CONTROL)
			outMode <= regWrData[5:4];

	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence wr_s(a);
		regWrite && regAddr == a;
	endsequence
	sequence rd_s(a);
		regRead && regAddr == a;
	endsequence

	// ==========================================================
	// Assertions
	rd_idle_a: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data not zero outside a read");
	force_zero_a: assert property (
		rd_s(tmw_pkg::OFF_CONTROL) |=> !regRdData[7])
		else $error("force strobe read back as one");
	ctl_back_a: assert property (
		wr_s(tmw_pkg::OFF_CONTROL) ##1 rd_s(tmw_pkg::OFF_CONTROL)
		|=> regRdData[6:0] == $past(regWrData[6:0], 2))
		else $error("control field readback wrong");
	cmp_back_a: assert property (
		wr_s(tmw_pkg::OFF_COMPARE) ##1 rd_s(tmw_pkg::OFF_COMPARE)
		|=> regRdData == $past(regWrData, 2))
		else $error("compare readback wrong");
	mask_back_a: assert property (
		wr_s(tmw_pkg::OFF_MASK) ##1 rd_s(tmw_pkg::OFF_MASK)
		|=> regRdData[1:0] == $past(regWrData[1:0], 2))
		else $error("mask readback wrong");
	cmp_gate_a: assert property (!globalIrqEnable |-> !compareIrqReq)
		else $error("compare request without global enable");
	ovf_gate_a: assert property (!globalIrqEnable |-> !overflowIrqReq)
		else $error("overflow request without global enable");
	oe_dir_a: assert property (compareOutPinOe_n == !pinDirection)
		else $error("pin enable does not follow direction");
	port_pass_a: assert property (
		outMode == 2'b00 |-> compareOutPin == portData)
		else $error("pin not port value while disconnected");
endmodule

bind tmw_timer tmw_timer_chk u_chk (.clk(clk), .arst_n(arst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData),
	.globalIrqEnable(globalIrqEnable), .compareIrqReq(compareIrqReq),
	.overflowIrqReq(overflowIrqReq), .pinDirection(pinDirection),
	.portData(portData), .compareOutPin(compareOutPin),
	.compareOutPinOe_n(compareOutPinOe_n));

// ---- dv/tmw_timer_tb.sv ----
// Self-checking bench for the 8-bit timer
`timescale 1ns/10ps
module tmw_timer_tb;
	localparam logic [7:0] ACTL = tmw_pkg::OFF_CONTROL;
	localparam logic [7:0] ACNT = tmw_pkg::OFF_COUNT;
	localparam logic [7:0] ACMP = tmw_pkg::OFF_COMPARE;
	localparam logic [7:0] AMSK = tmw_pkg::OFF_MASK;
	localparam logic [7:0] AFLG = tmw_pkg::OFF_FLAGS;
	logic clk;
	logic arst_n;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWrite;
	logic regRead;
	logic [7:0] regRdData;
	logic globalIrqEnable;
	logic compareVectorAck;
	logic overflowVectorAck;
	logic compareIrqReq;
	logic overflowIrqReq;
	logic pinDirection;
	logic portData;
	logic compareOutPin;
	logic compareOutPinOe_n;
	int fails;
	int samplesChecked;
	int cycles;

	tmw_timer u_tmw_timer (.clk(clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData),
		.globalIrqEnable(globalIrqEnable),
		.compareVectorAck(compareVectorAck),
		.overflowVectorAck(overflowVectorAck),
		.compareIrqReq(compareIrqReq), .overflowIrqReq(overflowIrqReq),
		.pinDirection(pinDirection), .portData(portData),
		.compareOutPin(compareOutPin),
		.compareOutPinOe_n(compareOutPinOe_n));

	// ==========================================================
	// Shared tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task wr8(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask

	// Data stands only in the cycle after the strobe
	task rd8(input logic [7:0] a, output logic [7:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask

	task rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd8(a, v);
		check(v, exp);
	endtask

	task pin(input logic e);
		@(posedge clk);
		check(compareOutPin, e);
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		rc(ACTL, tmw_pkg::RST_CONTROL);
		rc(ACNT, tmw_pkg::RST_COUNT);
		rc(ACMP, tmw_pkg::RST_COMPARE);
		rc(AMSK, tmw_pkg::RST_MASK);
		rc(8'h01, 8'h00);
		portData <= 1'b1;
		pin(1'b1);
		check(compareOutPinOe_n, 1'b0);
		portData <= 1'b0;
	endtask

	// Spans are whole tick periods, so the count delta is exact
	task t_prescale;
		int p[8] = '{2, 1, 8, 32, 64, 128, 256, 1024};
		logic [7:0] a;
		logic [7:0] b;
		for (int s = 0; s < 8; s++)
		begin
			wr8(ACTL, 8'(s));
			rd8(ACNT, a);
			repeat (4 * p[s] - 2) @(posedge clk);
			rd8(ACNT, b);
			check(8'(b - a), s ? 8'h04 : 8'h00);
		end
		wr8(ACTL, 8'h00);
	endtask

	task t_force;
		wr8(AFLG, 8'h03);
		wr8(ACNT, 8'h33);
		wr8(ACTL, 8'hA0);
		pin(1'b0);
		wr8(ACTL, 8'h90);
		pin(1'b1);
		wr8(ACTL, 8'h90);
		pin(1'b0);
		wr8(ACTL, 8'hB0);
		pin(1'b1);
		wr8(ACTL, 8'hA8);
		pin(1'b0);
		rc(ACNT, 8'h33);
		rc(AFLG, 8'h00);
		rc(ACTL, 8'h28);
		wr8(ACTL, 8'hF8);
		pin(1'b0);
		wr8(ACTL, 8'h00);
	endtask

	task t_irq;
		globalIrqEnable <= 1'b0;
		wr8(ACNT, 8'h00);
		wr8(ACMP, 8'h20);
		wr8(AFLG, 8'h03);
		wr8(AMSK, 8'h03);
		wr8(ACTL, 8'h01);
		repeat (40) @(posedge clk);
		wr8(ACTL, 8'h00);
		check(compareIrqReq, 1'b0);
		rc(AFLG, 8'h02);
		globalIrqEnable <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		check(compareIrqReq, 1'b1);
		check(overflowIrqReq, 1'b0);
		compareVectorAck <= 1'b1;
		@(posedge clk);
		compareVectorAck <= 1'b0;
		@(posedge clk);
		check(compareIrqReq, 1'b0);
		wr8(ACNT, 8'hFA);
		wr8(ACTL, 8'h01);
		repeat (12) @(posedge clk);
		wr8(ACTL, 8'h00);
		@(posedge clk);
		check(overflowIrqReq, 1'b1);
		wr8(AFLG, 8'h01);
		rc(AFLG, 8'h00);
		overflowVectorAck <= 1'b1;
		@(posedge clk);
		overflowVectorAck <= 1'b0;
	endtask

	task t_block;
		wr8(AFLG, 8'h03);
		wr8(ACNT, 8'h00);
		wr8(ACMP, 8'h50);
		wr8(ACTL, 8'h01);
		wr8(ACNT, 8'h50);
		wr8(ACTL, 8'h00);
		rc(AFLG, 8'h00);
	endtask

	// High time over one period, fast then phase, both polarities
	task t_pwm;
		logic [7:0] c[4] = '{8'h69, 8'h79, 8'h61, 8'h71};
		int w[4] = '{256, 256, 510, 510};
		int e[4] = '{65, 191, 128, 382};
		logic [15:0] h;
		for (int i = 0; i < 4; i++)
		begin
			wr8(ACNT, 8'h00);
			wr8(ACMP, 8'h40);
			wr8(ACTL, c[i]);
			repeat (600) @(posedge clk);
			h = 16'h0000;
			repeat (w[i])
			begin
				@(posedge clk);
				h = h + 16'(compareOutPin);
			end
			check(h, 16'(e[i]));
		end
		wr8(ACTL, 8'h00);
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fails++;
			test_done();
		end
	end

	initial
	begin
		{regAddr, regWrData, regWrite, regRead} = '0;
		{globalIrqEnable, compareVectorAck, overflowVectorAck} = '0;
		portData = 1'b0;
		pinDirection = 1'b1;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_prescale();
		t_force();
		t_irq();
		t_block();
		t_pwm();
		test_done();
	end
endmodule
